// *** rtl/gauge_cfg_pkg.sv ***
package gauge_cfg_pkg;

	// ------------------------------------------------------------
	// Operation configuration word layout
	// ------------------------------------------------------------
	localparam int unsigned     CFG_WIDTH            = 16;
	localparam logic [15:0]     CFG_RESET            = 16'h01f8;
	localparam int unsigned     BIT_SENSE_COMP       = 15;
	localparam int unsigned     BIT_PIN_DETECT       = 13;
	localparam int unsigned     BIT_PULLUP           = 12;
	localparam int unsigned     BIT_GND_SEL          = 11;
	localparam int unsigned     BIT_SLEEP_OK         = 5;
	localparam int unsigned     BIT_RELOAD_CAP       = 4;
	localparam int unsigned     BIT_LOW_BATT_SEL     = 2;
	localparam int unsigned     BIT_POLARITY         = 1;
	localparam int unsigned     BIT_HOST_TEMP        = 0;

	// ------------------------------------------------------------
	// Values and timing
	// ------------------------------------------------------------
	localparam logic [7:0]      SOC_FULL             = 8'h64;
	localparam logic [15:0]     TEMP_DEFAULT         = 16'h0ba6;
	localparam int unsigned     CLK_MHZ              = 50;
	localparam int unsigned     PULSE_TIME_US        = 1000;
	localparam int unsigned     PULSE_CYCLES         = PULSE_TIME_US * CLK_MHZ;
	localparam int unsigned     MS_TIME_US           = 1000;
	localparam int unsigned     MS_CYCLES            = MS_TIME_US * CLK_MHZ;
	localparam int unsigned     OT_TIME_MS           = 2000;
	localparam int unsigned     PEND_WIDTH           = 3;

	// ------------------------------------------------------------
	// Battery state and alert pulse sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BATT_RELAX     = 2'h0,
		BATT_CHARGE    = 2'h1,
		BATT_DISCHARGE = 2'h2
	} batt_state_type;

	typedef enum logic [2:0] {
		PULSE_IDLE = 3'h1,
		PULSE_HIGH = 3'h2,
		PULSE_GAP  = 3'h4
	} pulse_state_type;

endpackage

// *** rtl/gauge_config_alert_logic.sv ***
`timescale 1ns/10ps

// Function
// - High bit 7 enables sense resistor temperature compensation, default clear.
// - High bit 5 selects detect pin presence, else host subcommands only.
// - High bit 3 selects alternate converter ground, default ground when clear.
// - Low bit 5 permits sleep when conditions allow, default set.
// - Low bit 4 reloads remaining capacity from full capacity at termination.
// - Low bit 2 selects low-battery output, else charge-level pulses.
// - Low bit 1 makes the output active high, else active low.
// - Low bit 0 lets the host write temperature, else internal sensor.
// - Low-battery mode output follows the first low-charge flag with polarity.
// - First flag sets below its threshold, clears above that threshold.
// - Final flag sets below threshold, clears above separate clear threshold.
// - Each cycle with a qualifying interrupt event gives one 1 ms output pulse, up to 7 pending.
// - Pulse on charge reaching or discharge dropping below interval boundaries.
// - With a nonzero interval step, pulse on any change among charging, discharging and relaxation.
// - With pin detection, pulse once when the pin reports removal.
// - Gauge only after insertion and initialization; otherwise gauging stays stopped.
// - Host temperature starts at 25 C; gauging uses reported temperature.
// - Charge over-temperature after 2 s hot with charge current; clears at recovery.
// - Discharge over-temperature after 2 s hot with discharge current; clears at recovery.
module gauge_config_alert_logic
	import gauge_cfg_pkg::*;
#(
	parameter int unsigned PULSE_LEN = PULSE_CYCLES,
	parameter int unsigned MS_LEN    = MS_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Configuration word access
	input  wire logic        cfg_wr,
	input  wire logic [15:0] cfg_wdata,
	output logic      [15:0] cfg_rdata,
	// Decoded configuration outputs
	output logic             sense_res_temp_comp_en,
	output logic             detect_pin_pullup_en,
	output logic             adc_ground_select,
	output logic             sleep_allowed,
	// Gauge measurements
	input  wire logic [7:0]  state_of_charge,
	input  wire logic [1:0]  batt_state,
	input  wire logic signed [15:0] average_current,
	input  wire logic [15:0] sensor_temp,
	// Thresholds
	input  wire logic [7:0]  first_set_thr,
	input  wire logic [7:0]  final_set_thr,
	input  wire logic [7:0]  final_clr_thr,
	input  wire logic [7:0]  interval_step,
	input  wire logic [15:0] chg_current_thr,
	input  wire logic [15:0] dsg_current_thr,
	input  wire logic [15:0] ot_chg_thr,
	input  wire logic [15:0] ot_chg_recovery,
	input  wire logic [15:0] ot_dsg_thr,
	input  wire logic [15:0] ot_dsg_recovery,
	// Host temperature write
	input  wire logic        temp_wr,
	input  wire logic [15:0] temp_wdata,
	output logic      [15:0] temperature,
	// Battery detection
	input  wire logic        battery_detect_pin,
	input  wire logic        insert_subcommand,
	input  wire logic        remove_subcommand,
	input  wire logic        init_done,
	output logic             battery_present_bit,
	output logic             gauging_active,
	// Charge termination
	input  wire logic        charge_term_valid,
	output logic             reload_capacity_strobe,
	// Flags and alert pin
	output logic             first_low_charge_flag,
	output logic             final_low_charge_flag,
	output logic             charge_overtemp_flag,
	output logic             discharge_overtemp_flag,
	output logic             alert_output_pin
);

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	logic [15:0]            cfg_q;
	logic                   pin_insert_detect_en;
	logic                   low_batt_output_select;
	logic                   output_polarity;
	logic                   host_temp_write_en;
	logic                   reload_capacity_on_term;

	// Reserved bits are stored as written; keeping them right is the host's job
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_q <= CFG_RESET;
		end else if (cfg_wr) begin
			cfg_q <= cfg_wdata;
		end
	end

	// Field decode
	assign cfg_rdata               = cfg_q;
	assign sense_res_temp_comp_en  = cfg_q[BIT_SENSE_COMP];
	assign pin_insert_detect_en    = cfg_q[BIT_PIN_DETECT];
	assign detect_pin_pullup_en    = cfg_q[BIT_PULLUP];
	assign adc_ground_select       = cfg_q[BIT_GND_SEL];
	assign sleep_allowed           = cfg_q[BIT_SLEEP_OK];
	assign reload_capacity_on_term = cfg_q[BIT_RELOAD_CAP];
	assign low_batt_output_select  = cfg_q[BIT_LOW_BATT_SEL];
	assign output_polarity         = cfg_q[BIT_POLARITY];
	assign host_temp_write_en      = cfg_q[BIT_HOST_TEMP];

	// ------------------------------------------------------------
	// Capacity reload and temperature source
	// ------------------------------------------------------------
	logic [15:0]            temp_q;
	logic                   host_temp_en_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			reload_capacity_strobe <= 1'b0;
		end else begin
			reload_capacity_strobe <= charge_term_valid & reload_capacity_on_term;
		end
	end

	// restart at 25 C on selection
	always_ff @(posedge clk) begin
		if (rst) begin
			temp_q         <= TEMP_DEFAULT;
			host_temp_en_q <= 1'b0;
		end else begin
			host_temp_en_q <= host_temp_write_en;
			if (!host_temp_write_en) begin
				temp_q <= sensor_temp;
			end else if (temp_wr) begin
				temp_q <= temp_wdata;
			end else if (!host_temp_en_q) begin
				temp_q <= TEMP_DEFAULT;
			end
		end
	end

	assign temperature = temp_q;

	// ------------------------------------------------------------
	// Battery detection
	// ------------------------------------------------------------
	logic                   pin_meta_q;
	logic                   pin_sync_q;
	logic                   pin_prev_q;
	logic                   host_present_q;
	logic                   removal_event;

	// Pin comes from outside, so two flops before any use
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
			pin_prev_q <= 1'b1;
		end else begin
			pin_meta_q <= battery_detect_pin;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// host subcommands; insert wins if both arrive together
	always_ff @(posedge clk) begin
		if (rst) begin
			host_present_q <= 1'b0;
		end else if (insert_subcommand) begin
			host_present_q <= 1'b1;
		end else if (remove_subcommand) begin
			host_present_q <= 1'b0;
		end
	end

	// low means inserted, rising edge means removal
	assign battery_present_bit = pin_insert_detect_en ? ~pin_sync_q : host_present_q;
	assign removal_event       = pin_insert_detect_en & pin_sync_q & ~pin_prev_q;

	// gauge only when present and initialized
	always_ff @(posedge clk) begin
		if (rst) begin
			gauging_active <= 1'b0;
		end else begin
			gauging_active <= battery_present_bit & init_done;
		end
	end

	// ------------------------------------------------------------
	// Low-charge flags
	// ------------------------------------------------------------
	// first flag hysteresis-free
	always_ff @(posedge clk) begin
		if (rst) begin
			first_low_charge_flag <= 1'b0;
		end else if (state_of_charge < first_set_thr) begin
			first_low_charge_flag <= 1'b1;
		end else if (state_of_charge > first_set_thr) begin
			first_low_charge_flag <= 1'b0;
		end
	end

	// final flag with separate clear level
	always_ff @(posedge clk) begin
		if (rst) begin
			final_low_charge_flag <= 1'b0;
		end else if (state_of_charge < final_set_thr) begin
			final_low_charge_flag <= 1'b1;
		end else if (final_low_charge_flag && state_of_charge > final_clr_thr) begin
			final_low_charge_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Over-temperature flags, timed on a millisecond enable
	// ------------------------------------------------------------
	logic [15:0]            ms_cnt_q;
	logic                   ms_tick;
	logic [1:0]             hot_cond;
	logic [1:0][15:0]       hot_recovery;
	logic [1:0]             hot_flag;

	// Millisecond divider
	always_ff @(posedge clk) begin
		if (rst || ms_cnt_q == 16'(MS_LEN - 1)) begin
			ms_cnt_q <= 16'h0000;
		end else begin
			ms_cnt_q <= ms_cnt_q + 16'h0001;
		end
	end

	assign ms_tick      = (ms_cnt_q == 16'(MS_LEN - 1));
	assign hot_cond[0]  = (batt_state == BATT_CHARGE) && (temp_q >= ot_chg_thr) &&
		(average_current > $signed({1'b0, chg_current_thr[14:0]}));
	assign hot_cond[1]  = (batt_state == BATT_DISCHARGE) && (temp_q >= ot_dsg_thr) &&
		(average_current <= -$signed({1'b0, dsg_current_thr[14:0]}));
	assign hot_recovery = {ot_dsg_recovery, ot_chg_recovery};

	// one timer per leg
	// Any break of the condition restarts the hold time from zero
	for (genvar i = 0; i < 2; i++) begin : g_hot
		logic [11:0] hold_ms_q;
		logic        flag_q;

		always_ff @(posedge clk) begin
			if (rst || !hot_cond[i]) begin
				hold_ms_q <= 12'h000;
			end else if (ms_tick && hold_ms_q != 12'(OT_TIME_MS)) begin
				hold_ms_q <= hold_ms_q + 12'h001;
			end
		end

		// Set wins over recovery in the same cycle
		always_ff @(posedge clk) begin
			if (rst) begin
				flag_q <= 1'b0;
			end else if (hot_cond[i] && hold_ms_q == 12'(OT_TIME_MS)) begin
				flag_q <= 1'b1;
			end else if (temp_q <= hot_recovery[i]) begin
				flag_q <= 1'b0;
			end
		end

		assign hot_flag[i] = flag_q;
	end

	assign charge_overtemp_flag    = hot_flag[0];
	assign discharge_overtemp_flag = hot_flag[1];

	// ------------------------------------------------------------
	// Interrupt event detection
	// ------------------------------------------------------------
	logic [7:0]             level_d;
	logic [7:0]             level_q;
	logic [1:0]             state_prev_q;
	logic                   step_on;
	logic                   interval_event;
	logic                   state_event;
	logic                   any_event;

	// Level counts boundaries strictly above SOC; a divider is cheaper here
	// than a table because the step is programmable
	assign step_on = (interval_step != 8'h00);
	always_comb begin
		if (step_on && state_of_charge <= SOC_FULL) begin
			level_d = 8'((9'(SOC_FULL - state_of_charge) + 9'(interval_step) - 9'h001) / 9'(interval_step));
		end else begin
			level_d = 8'h00;
		end
	end

	assign interval_event = step_on && (
		((batt_state == BATT_CHARGE) && (level_d < level_q)) ||
		((batt_state == BATT_DISCHARGE) && (level_d > level_q)));
	assign state_event    = step_on && (batt_state != state_prev_q);
	assign any_event      = interval_event | state_event | removal_event;

	always_ff @(posedge clk) begin
		if (rst) begin
			level_q      <= 8'h00;
			state_prev_q <= BATT_RELAX;
		end else begin
			level_q      <= level_d;
			state_prev_q <= batt_state;
		end
	end

	// ------------------------------------------------------------
	// Pulse sequencer
	// ------------------------------------------------------------
	pulse_state_type        pstate_q;
	logic [15:0]            pcnt_q;
	logic [2:0]             pend_q;
	logic                   pcnt_done;
	logic                   pulse_take;

	assign pcnt_done  = (pcnt_q == 16'(PULSE_LEN - 1));
	assign pulse_take = (pstate_q == PULSE_IDLE) && (pend_q != 3'h0);

	// Events queue up to 7 pending and further ones are dropped; an arrival and a take in the same cycle leave the count unchanged
	always_ff @(posedge clk) begin
		if (rst || low_batt_output_select) begin
			pend_q <= 3'h0;
		end else if (any_event && !pulse_take) begin
			pend_q <= (pend_q == 3'h7) ? pend_q : pend_q + 3'h1;
		end else if (!any_event && pulse_take) begin
			pend_q <= pend_q - 3'h1;
		end
	end

	// one full 1 ms pulse, then an equal gap so pulses stay apart
	always_ff @(posedge clk) begin
		if (rst || low_batt_output_select) begin
			pstate_q <= PULSE_IDLE;
			pcnt_q   <= 16'h0000;
		end else begin
			case (pstate_q)
				PULSE_IDLE: begin
					pcnt_q <= 16'h0000;
					if (pulse_take) begin
						pstate_q <= PULSE_HIGH;
					end
				end
				PULSE_HIGH: begin
					pcnt_q <= pcnt_done ? 16'h0000 : pcnt_q + 16'h0001;
					if (pcnt_done) begin
						pstate_q <= PULSE_GAP;
					end
				end
				PULSE_GAP: begin
					pcnt_q <= pcnt_done ? 16'h0000 : pcnt_q + 16'h0001;
					if (pcnt_done) begin
						pstate_q <= PULSE_IDLE;
					end
				end
				default: begin
					pstate_q <= PULSE_IDLE;
					pcnt_q   <= 16'h0000;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Alert pin
	// ------------------------------------------------------------
	logic                   alert_active;

	// low-battery mode mirrors the first flag
	assign alert_active = low_batt_output_select ? first_low_charge_flag : (pstate_q == PULSE_HIGH);

	always_ff @(posedge clk) begin
		if (rst) begin
			alert_output_pin <= 1'b1;
		end else begin
			alert_output_pin <= output_polarity ? alert_active : ~alert_active;
		end
	end

endmodule

// *** test/gauge_host_model.sv ***
`timescale 1ns/10ps
// ----------
// Host side of battery detection
// ----------
module gauge_host_model (
	// Clock
	input  wire logic clk,
	// Wanted pack state and detect method
	input  wire logic present,
	input  wire logic pin_mode,
	// Detect pin and subcommand strobes
	output logic      battery_detect_pin = 1'b1,
	output logic      insert_subcommand  = 1'b0,
	output logic      remove_subcommand  = 1'b0
);
	logic was_q = 1'b0;

	// pack pulls pin low
	// Pull-up holds the pin high whenever the pack is out or unused
	always @(posedge clk) begin
		battery_detect_pin <= #1 !(pin_mode && present);
		insert_subcommand  <= #1 !pin_mode && present && !was_q;
		remove_subcommand  <= #1 !pin_mode && !present && was_q;
		was_q              <= present;
	end
endmodule

// *** test/gauge_config_alert_logic_monitor.sv ***
`timescale 1ns/10ps
// ----------
// Alert and flag checker
// ----------
module gauge_alert_monitor #(
	parameter int unsigned PULSE_LEN = 20
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Observed ports
	input wire logic        cfg_wr,
	input wire logic [15:0] cfg_wdata,
	input wire logic [15:0] cfg_rdata,
	input wire logic        sense_res_temp_comp_en,
	input wire logic        detect_pin_pullup_en,
	input wire logic        adc_ground_select,
	input wire logic        sleep_allowed,
	input wire logic [7:0]  state_of_charge,
	input wire logic [1:0]  batt_state,
	input wire logic [7:0]  first_set_thr,
	input wire logic [7:0]  final_set_thr,
	input wire logic        charge_term_valid,
	input wire logic        reload_capacity_strobe,
	input wire logic        first_low_charge_flag,
	input wire logic        final_low_charge_flag,
	input wire logic        charge_overtemp_flag,
	input wire logic        discharge_overtemp_flag,
	input wire logic        alert_output_pin
);
	logic [15:0] run_q;

	// Active run length; cleared around mode writes so a mode swap is not a pulse
	always_ff @(posedge clk) begin
		if (rst || cfg_rdata[2] || cfg_wr || $past(cfg_wr) || alert_output_pin != cfg_rdata[1])
			run_q <= 16'h0;
		else
			run_q <= run_q + 16'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	cfg_store_a: assert property (cfg_wr |=> cfg_rdata == $past(cfg_wdata))
		else $error("config word not stored");
	cfg_decode_a: assert property ({sense_res_temp_comp_en, detect_pin_pullup_en, adc_ground_select,
		sleep_allowed} == {cfg_rdata[15], cfg_rdata[12], cfg_rdata[11], cfg_rdata[5]})
		else $error("config decode wrong");
	term_reload_a: assert property (!cfg_wr |=> reload_capacity_strobe == ($past(charge_term_valid) && cfg_rdata[4]))
		else $error("reload strobe wrong");
	low_batt_pin_a: assert property (cfg_rdata[2] && !$past(cfg_wr) |->
		alert_output_pin == ($past(first_low_charge_flag) ~^ cfg_rdata[1]))
		else $error("low battery pin wrong");
	first_set_a: assert property (state_of_charge < first_set_thr |=> first_low_charge_flag)
		else $error("first flag not set");
	first_clear_a: assert property (state_of_charge > first_set_thr |=> !first_low_charge_flag)
		else $error("first flag not cleared");
	final_set_a: assert property (state_of_charge < final_set_thr |=> final_low_charge_flag)
		else $error("final flag not set");
	final_hold_a: assert property (!final_low_charge_flag && state_of_charge >= final_set_thr |=> !final_low_charge_flag)
		else $error("final flag set early");
	pulse_width_a: assert property (run_q != 0 && alert_output_pin != cfg_rdata[1] |-> run_q == PULSE_LEN)
		else $error("pulse width wrong");
	chg_hot_a: assert property ($rose(charge_overtemp_flag) |-> $past(batt_state) == 2'h1)
		else $error("charge overtemp outside charge");
	dsg_hot_a: assert property ($rose(discharge_overtemp_flag) |-> $past(batt_state) == 2'h2)
		else $error("discharge overtemp outside discharge");

	cover property (run_q == PULSE_LEN);
	cover property (cfg_rdata[2] && first_low_charge_flag);
	cover property ($rose(charge_overtemp_flag));
	cover property ($rose(discharge_overtemp_flag));
endmodule

bind gauge_config_alert_logic gauge_alert_monitor #(.PULSE_LEN(PULSE_LEN)) gauge_alert_monitor_inst (.*);

// *** test/gauge_config_alert_logic_tb.sv ***
`timescale 1ns/10ps
module gauge_config_alert_logic_tb;
	// ----------
	// Signals
	// ----------
	localparam int PL = 20;
	logic clk = 0, rst = 1, cfg_wr = 0, temp_wr = 0, init_done = 0, charge_term_valid = 0, present = 0, pin_mode = 0;
	logic [15:0] cfg_wdata = 0, temp_wdata = 0, sensor_temp = 16'h0c00, chg_current_thr = 16'h0064;
	logic [15:0] dsg_current_thr = 16'h0064, ot_chg_thr = 16'h0ce4, ot_chg_recovery = 16'h0c80;
	logic [15:0] ot_dsg_thr = 16'h0ce4, ot_dsg_recovery = 16'h0c80;
	logic signed [15:0] average_current = 16'sh0;
	logic [7:0] state_of_charge = 8'h5f, first_set_thr = 8'h14, final_set_thr = 8'h0a, final_clr_thr = 8'h0f;
	logic [7:0] interval_step = 8'h00;
	logic [1:0] batt_state = 2'h0;
	logic [15:0] cfg_rdata, temperature;
	logic sense_res_temp_comp_en, detect_pin_pullup_en, adc_ground_select, sleep_allowed, battery_detect_pin;
	logic insert_subcommand, remove_subcommand, battery_present_bit, gauging_active, reload_capacity_strobe;
	logic first_low_charge_flag, final_low_charge_flag, charge_overtemp_flag, discharge_overtemp_flag;
	logic alert_output_pin;
	int error_cnt = 0, n_compared = 0;

	gauge_config_alert_logic #(.PULSE_LEN(PL), .MS_LEN(1)) gauge_config_alert_logic_inst (.*);
	gauge_host_model gauge_host_model_inst (.*);

	// Free running 50 MHz clock
	always #10 clk = ~clk;

	// ----------
	// Tasks
	// ----------
	// Inputs move 1 ns after the edge so sampling never races
	task tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wcfg(logic [15:0] v);
		cfg_wr = 1;
		cfg_wdata = v;
		tick(1);
		cfg_wr = 0;
		tick(1);
	endtask

	task term(logic e);
		charge_term_valid = 1;
		tick(1);
		charge_term_valid = 0;
		chk("reload", reload_capacity_strobe, e);
		tick(1);
	endtask

	// Active cycles in a window tell pulse count and width at once
	task act(int e);
		int n;
		n = 0;
		repeat (60) begin
			tick(1);
			if (alert_output_pin === cfg_rdata[1])
				n++;
		end
		chk("active cycles", n[15:0], 16'(e * PL));
	endtask

	task ot(logic [1:0] st, logic [15:0] cur, logic [1:0] e);
		batt_state = st;
		average_current = cur;
		sensor_temp = 16'h0cf0;
		tick(1990);
		chk("ot early", {charge_overtemp_flag, discharge_overtemp_flag}, 0);
		tick(20);
		chk("ot set", {charge_overtemp_flag, discharge_overtemp_flag}, e);
		sensor_temp = 16'h0c6c;
		tick(3);
		chk("ot clear", {charge_overtemp_flag, discharge_overtemp_flag}, 0);
	endtask

	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard
	initial begin
		#1000000;
		error_cnt++;
		print_verdict;
	end

	// ----------
	// Main sequence
	// ----------
	initial begin
		tick(2);
		chk("cfg reset", cfg_rdata, 16'h01f8);
		chk("temp reset", temperature, 16'h0ba6);
		chk("pin reset", alert_output_pin, 1);
		rst = 0;
		tick(1);
		wcfg(16'h99c8);
		chk("cfg", cfg_rdata, 16'h99c8);
		chk("decode", {sense_res_temp_comp_en, detect_pin_pullup_en, adc_ground_select, sleep_allowed}, 4'he);
		term(0);
		wcfg(16'h01f8);
		term(1);
		chk("sleep", sleep_allowed, 1);
		$display("Section config done");
		sensor_temp = 16'h0c10;
		tick(2);
		chk("temp sensor", temperature, 16'h0c10);
		wcfg(16'h01f9);
		chk("temp default", temperature, 16'h0ba6);
		sensor_temp = 16'h0c20;
		temp_wr = 1;
		temp_wdata = 16'h0b00;
		tick(1);
		temp_wr = 0;
		tick(2);
		chk("temp host", temperature, 16'h0b00);
		wcfg(16'h01f8);
		tick(1);
		chk("temp back", temperature, 16'h0c20);
		temp_wr = 1;
		tick(1);
		temp_wr = 0;
		tick(1);
		chk("temp ignored", temperature, 16'h0c20);
		$display("Section temperature done");
		present = 1;
		tick(3);
		chk("present", battery_present_bit, 1);
		chk("gauge idle", gauging_active, 0);
		init_done = 1;
		tick(2);
		chk("gauge on", gauging_active, 1);
		present = 0;
		tick(3);
		chk("gauge off", gauging_active, 0);
		$display("Section detect done");
		wcfg(16'h01fc);
		state_of_charge = 8'h1e;
		tick(3);
		chk("first", first_low_charge_flag, 0);
		chk("pin idle", alert_output_pin, 1);
		state_of_charge = 8'h0a;
		tick(3);
		chk("first", first_low_charge_flag, 1);
		chk("pin low", alert_output_pin, 0);
		wcfg(16'h01fe);
		tick(1);
		chk("pin high", alert_output_pin, 1);
		state_of_charge = 8'h14;
		tick(3);
		chk("first hold", first_low_charge_flag, 1);
		state_of_charge = 8'h15;
		tick(3);
		chk("first", first_low_charge_flag, 0);
		chk("pin", alert_output_pin, 0);
		state_of_charge = 8'h05;
		tick(3);
		chk("final", final_low_charge_flag, 1);
		state_of_charge = 8'h0c;
		tick(3);
		chk("final hold", final_low_charge_flag, 1);
		state_of_charge = 8'h10;
		tick(3);
		chk("final", final_low_charge_flag, 0);
		$display("Section flags done");
		interval_step = 8'h0a;
		state_of_charge = 8'h5f;
		batt_state = 2'h2;
		tick(5);
		wcfg(16'h01f8);
		act(0);
		state_of_charge = 8'h59;
		act(1);
		state_of_charge = 8'h55;
		act(0);
		batt_state = 2'h1;
		act(1);
		state_of_charge = 8'h5a;
		act(1);
		state_of_charge = 8'h64;
		act(1);
		interval_step = 8'h00;
		batt_state = 2'h0;
		act(0);
		wcfg(16'h21f8);
		pin_mode = 1;
		present = 1;
		act(0);
		chk("pin present", battery_present_bit, 1);
		present = 0;
		act(1);
		chk("pin absent", battery_present_bit, 0);
		$display("Section pulses done");
		ot(2'h1, 16'h01f4, 2'b10);
		ot(2'h1, 16'h0064, 2'b00);
		ot(2'h2, 16'hff9c, 2'b01);
		$display("Section overtemp done");
		print_verdict;
	end
endmodule
